// ==== design/mth_ext_if.sv ====
`timescale 1ns/1ps
interface mth_ext_if;
  import mth_pkg::*;

  logic [ACC_W-1:0]  acc;
  mth_mode_e         mode;
  logic              rnd_biased;
  logic [HALF_W-1:0] half;

  modport lane (output acc, output mode, output rnd_biased, input half);
  modport ext  (input acc, input mode, input rnd_biased, output half);
endinterface

// ==== design/mth_extract.sv ====
`timescale 1ns/1ps
module mth_extract
  import mth_pkg::*;
(
  mth_ext_if.ext x
);

  logic        unsig;
  logic        intg;
  logic [40:0] ext41;
  logic [40:0] sum41;
  logic [40:0] q41;
  logic        fits;

  // ----------------------------------------------------------------
  // Round or truncate, then saturate to a half-word
  // ----------------------------------------------------------------
  always_comb begin
    unsig = (x.mode == MODE_UFRAC) || (x.mode == MODE_UINT);
    intg  = (x.mode == MODE_SINT) || (x.mode == MODE_UINT);
    ext41 = unsig ? {1'b0, x.acc} : {x.acc[ACC_W-1], x.acc};
    sum41 = ext41 + {25'h000_0000, ROUND_HALF};
    if (intg) begin
      q41 = ext41;
    end else if (x.mode == MODE_CHOP) begin
      q41 = {{16{ext41[40]}}, ext41[40:RND_POS]};
    end else begin
      q41 = {{16{sum41[40]}}, sum41[40:RND_POS]};
      if (!x.rnd_biased && (x.acc[RND_POS-1:0] == ROUND_HALF)) begin
        q41[0] = 1'b0;
      end
    end
    // Saturation acts on the rounded value
    if (unsig) begin
      fits = (q41[40:16] == 25'h000_0000);
    end else begin
      fits = (q41[40:15] == 26'h000_0000) || (q41[40:15] == 26'h3FF_FFFF);
    end
    if (fits) begin
      x.half = q41[HALF_W-1:0];
    end else if (unsig) begin
      x.half = HALF_UMAX;
    end else begin
      x.half = q41[40] ? HALF_SMIN : HALF_SMAX;
    end
  end

endmodule

// ==== design/mth_mac_half.sv ====
`timescale 1ns/1ps
module mth_mac_half
  import mth_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              aw_got_ff,  nxt_aw_got;
  logic [ADDR_W-1:0] awaddr_ff,  nxt_awaddr;
  logic              w_got_ff,   nxt_w_got;
  logic [DATA_W-1:0] wdata_ff,   nxt_wdata;
  logic [3:0]        wstrb_ff,   nxt_wstrb;
  logic              awready_ff, nxt_awready;
  logic              wready_ff,  nxt_wready;
  logic              bvalid_ff,  nxt_bvalid;
  logic [1:0]        bresp_ff,   nxt_bresp;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff,  nxt_rvalid;
  logic [1:0]        rresp_ff,   nxt_rresp;
  logic [DATA_W-1:0] rdata_ff,   nxt_rdata;
  logic              rnd_sel_ff, nxt_rnd_sel;
  logic [DATA_W-1:0] opnd_ff     [LANES];
  logic [DATA_W-1:0] nxt_opnd    [LANES];
  logic [CMD_W-1:0]  cmd_ff,     nxt_cmd;
  logic [DATA_W-1:0] dest_ff,    nxt_dest;
  logic [ACC_W-1:0]  acc_ff      [LANES];
  logic [ACC_W-1:0]  nxt_acc     [LANES];
  logic [HALF_W-1:0] lane_half   [LANES];
  logic              exec;
  logic              dest_wr;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // Byte-lane merge of a register write
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0]        strb);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Write channels and register updates
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response after both
  always_comb begin
    nxt_aw_got  = aw_got_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_got   = w_got_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rnd_sel = rnd_sel_ff;
    nxt_opnd    = opnd_ff;
    nxt_cmd     = cmd_ff;
    exec        = 1'b0;
    dest_wr     = 1'b0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = RESP_OKAY;
      case (awaddr_ff)
        FLAGS_OFS: begin
          if (wstrb_ff[0]) begin
            nxt_rnd_sel = wdata_ff[RND_SEL_BIT];
          end
        end
        OPND0_OFS: begin
          nxt_opnd[0] = merge(opnd_ff[0], wdata_ff, wstrb_ff);
        end
        OPND1_OFS: begin
          nxt_opnd[1] = merge(opnd_ff[1], wdata_ff, wstrb_ff);
        end
        CMD_OFS: begin
          nxt_cmd = CMD_W'(merge({22'h00_0000, cmd_ff}, wdata_ff, wstrb_ff));
          exec    = wstrb_ff[0];
        end
        DEST_OFS: begin
          dest_wr = 1'b1;
        end
        ACC0_LO_OFS, ACC0_HI_OFS, ACC1_LO_OFS, ACC1_HI_OFS: begin
          nxt_bresp = RESP_OKAY;
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready  = !nxt_w_got && !nxt_bvalid;
  end

  // Registers the write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      awaddr_ff  <= '0;
      w_got_ff   <= 1'b0;
      wdata_ff   <= REG_RST;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      rnd_sel_ff <= 1'b0;
      opnd_ff[0] <= REG_RST;
      opnd_ff[1] <= REG_RST;
      cmd_ff     <= CMD_RST;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      awaddr_ff  <= nxt_awaddr;
      w_got_ff   <= nxt_w_got;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rnd_sel_ff <= nxt_rnd_sel;
      opnd_ff    <= nxt_opnd;
      cmd_ff     <= nxt_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Multiply-accumulate lanes
  // ----------------------------------------------------------------
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    mth_ext_if ext_if ();

    mth_mode_e          mode;
    mth_op_e            op;
    logic               en;
    logic               sbu;
    logic               unsig;
    logic               frac_shift;
    logic [HALF_W-1:0]  opa;
    logic [HALF_W-1:0]  opb;
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    logic signed [33:0] prod;
    logic [33:0]        pr;
    logic [41:0]        p42;
    logic [41:0]        a42;
    logic [41:0]        sum42;
    logic [ACC_W-1:0]   acc_new;

    // Operand forming, product, accumulate and accumulator saturation
    always_comb begin
      case (nxt_cmd[CMD_MODE_LSB +: 3])
        3'h1:    mode = MODE_UFRAC;
        3'h2:    mode = MODE_SINT;
        3'h3:    mode = MODE_UINT;
        3'h4:    mode = MODE_CHOP;
        default: mode = MODE_DEFAULT;
      endcase
      case (nxt_cmd[(i == 0 ? CMD_OP0_LSB : CMD_OP1_LSB) +: 2])
        2'h1:    op = OP_ADD;
        2'h2:    op = OP_SUB;
        default: op = OP_LOAD;
      endcase
      en         = nxt_cmd[i == 0 ? CMD_EN0_BIT : CMD_EN1_BIT];
      sbu        = (i == 1) && nxt_cmd[CMD_SBU_BIT];
      unsig      = (mode == MODE_UFRAC) || (mode == MODE_UINT);
      frac_shift = ((mode == MODE_DEFAULT) || (mode == MODE_CHOP)) && !sbu;
      opa        = opnd_ff[i][HALF_W-1:0];
      opb        = opnd_ff[i][DATA_W-1:HALF_W];
      ea         = {(!unsig || sbu) & opa[HALF_W-1], opa};
      eb         = {(!unsig && !sbu) & opb[HALF_W-1], opb};
      prod       = ea * eb;
      if (frac_shift && (opa == FRAC_NEG1) && (opb == FRAC_NEG1)) begin
        pr = PROD_FMAX;
      end else if (frac_shift) begin
        pr = 34'(prod <<< 1);
      end else begin
        pr = prod;
      end
      p42 = {{8{pr[33]}}, pr};
      a42 = unsig ? {2'b00, acc_ff[i]} : {{2{acc_ff[i][ACC_W-1]}}, acc_ff[i]};
      case (op)
        OP_ADD:  sum42 = a42 + p42;
        OP_SUB:  sum42 = a42 - p42;
        default: sum42 = p42;
      endcase
      if (unsig) begin
        if (sum42[41]) begin
          acc_new = ACC_UMIN;
        end else if (sum42[40]) begin
          acc_new = ACC_UMAX;
        end else begin
          acc_new = sum42[ACC_W-1:0];
        end
      end else if (sum42[41:39] == 3'h0 || sum42[41:39] == 3'h7) begin
        acc_new = sum42[ACC_W-1:0];
      end else begin
        acc_new = sum42[41] ? ACC_SMIN : ACC_SMAX;
      end
      nxt_acc[i] = (exec && en) ? acc_new : acc_ff[i];
    end

    assign ext_if.acc        = acc_new;
    assign ext_if.mode       = mode;
    assign ext_if.rnd_biased = rnd_sel_ff;
    assign lane_half[i]      = ext_if.half;

    mth_extract u_extract (
      .x (ext_if.ext)
    );
  end

  // Destination register: software write or lane results
  always_comb begin
    nxt_dest = dest_ff;
    if (dest_wr) begin
      nxt_dest = merge(dest_ff, wdata_ff, wstrb_ff);
    end
    if (exec && nxt_cmd[CMD_EN0_BIT]) begin
      nxt_dest[HALF_W-1:0] = lane_half[0];
    end
    if (exec && nxt_cmd[CMD_EN1_BIT]) begin
      nxt_dest[DATA_W-1:HALF_W] = lane_half[1];
    end
  end

  // Accumulators change only by an accumulate step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff[0] <= ACC_RST;
      acc_ff[1] <= ACC_RST;
      dest_ff   <= REG_RST;
    end else begin
      acc_ff    <= nxt_acc;
      dest_ff   <= nxt_dest;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read at a time; unmapped addresses answer with an error
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        FLAGS_OFS:   nxt_rdata = {31'h0000_0000, rnd_sel_ff};
        OPND0_OFS:   nxt_rdata = opnd_ff[0];
        OPND1_OFS:   nxt_rdata = opnd_ff[1];
        CMD_OFS:     nxt_rdata = {22'h00_0000, cmd_ff};
        DEST_OFS:    nxt_rdata = dest_ff;
        ACC0_LO_OFS: nxt_rdata = acc_ff[0][DATA_W-1:0];
        ACC0_HI_OFS: nxt_rdata = {24'h00_0000, acc_ff[0][ACC_W-1:DATA_W]};
        ACC1_LO_OFS: nxt_rdata = acc_ff[1][DATA_W-1:0];
        ACC1_HI_OFS: nxt_rdata = {24'h00_0000, acc_ff[1][ACC_W-1:DATA_W]};
        default: begin
          nxt_rdata = REG_RST;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  // Registers the read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= REG_RST;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

endmodule

// ==== design/mth_pkg.sv ====
package mth_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HALF_W = 16;
  localparam int ACC_W  = 40;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CMD_W  = 10;
  localparam int LANES  = 2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FLAGS_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] OPND0_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] OPND1_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] CMD_OFS     = 8'h0C;
  localparam logic [ADDR_W-1:0] DEST_OFS    = 8'h10;
  localparam logic [ADDR_W-1:0] ACC0_LO_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] ACC0_HI_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] ACC1_LO_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] ACC1_HI_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RND_SEL_BIT  = 0;
  localparam int CMD_OP0_LSB  = 0;
  localparam int CMD_OP1_LSB  = 2;
  localparam int CMD_EN0_BIT  = 4;
  localparam int CMD_EN1_BIT  = 5;
  localparam int CMD_MODE_LSB = 6;
  localparam int CMD_SBU_BIT  = 9;
  localparam int RND_POS      = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  ACC_RST = 40'h00_0000_0000;
  localparam logic [CMD_W-1:0]  CMD_RST = 10'h000;

  // ----------------------------------------------------------------
  // Arithmetic limits
  // ----------------------------------------------------------------
  localparam logic [ACC_W-1:0]  ACC_SMAX   = 40'h7F_FFFF_FFFF;
  localparam logic [ACC_W-1:0]  ACC_SMIN   = 40'h80_0000_0000;
  localparam logic [ACC_W-1:0]  ACC_UMAX   = 40'hFF_FFFF_FFFF;
  localparam logic [ACC_W-1:0]  ACC_UMIN   = 40'h00_0000_0000;
  localparam logic [HALF_W-1:0] HALF_SMAX  = 16'h7FFF;
  localparam logic [HALF_W-1:0] HALF_SMIN  = 16'h8000;
  localparam logic [HALF_W-1:0] HALF_UMAX  = 16'hFFFF;
  localparam logic [HALF_W-1:0] FRAC_NEG1  = 16'h8000;
  localparam logic [HALF_W-1:0] ROUND_HALF = 16'h8000;
  localparam logic [33:0]       PROD_FMAX  = 34'h0_7FFF_FFFF;

  // ----------------------------------------------------------------
  // Bus responses and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_DEFAULT,
    MODE_UFRAC,
    MODE_SINT,
    MODE_UINT,
    MODE_CHOP
  } mth_mode_e;

  typedef enum logic [1:0] {
    OP_LOAD,
    OP_ADD,
    OP_SUB
  } mth_op_e;

endpackage

// ==== testbench/mth_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Core-side master issuing operands and commands
// ----------------------------------------------------------------
module mth_host
  import mth_pkg::*;
(
  input  wire logic              aclk,
  output      logic [ADDR_W-1:0] awaddr,
  output      logic              awvalid,
  input  wire logic              awready,
  output      logic [DATA_W-1:0] wdata,
  output      logic [3:0]        wstrb,
  output      logic              wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output      logic              bready,
  output      logic [ADDR_W-1:0] araddr,
  output      logic              arvalid,
  input  wire logic              arready,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output      logic              rready
);
  int stall = 0;

  // Idle bus from time zero
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Command word; the mixed-sign flag is only ever sent with lane one
  function automatic logic [DATA_W-1:0] cmd(input logic [1:0] op0, input logic [1:0] op1,
                                            input logic [1:0] en, input logic [2:0] mode,
                                            input logic sbu);
    cmd = {22'h0, sbu & en[1], mode, en, op1, op0};
  endfunction

  // One write; released lines show the inverse of the last value
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
    repeat (stall) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // One read; the answer may be accepted late
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    repeat (stall) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

// ==== testbench/mth_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register bus timing checker
// ----------------------------------------------------------------
module mth_monitor
  import mth_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both write channels taken together, and a read address taken
  wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic rd_take = s_axi_arvalid && s_axi_arready;

  // Write response timing, code and hold
  a_write_answer_time: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_write_bad_addr: assert property (wr_take && s_axi_awaddr > ACC1_HI_OFS
    |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");

  // Read response timing, code and hold
  a_read_answer_time: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_bad_addr: assert property (rd_take && s_axi_araddr > ACC1_HI_OFS
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read answer not released");
  a_ready_release: assert property ($rose(aresetn)
    |=> s_axi_awready && s_axi_wready && s_axi_arready) else $error("not ready after reset");
endmodule

bind mth_mac_half mth_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the MAC block
// ----------------------------------------------------------------
module tb_top
  import mth_pkg::*;
;
  typedef struct packed {
    logic              rnd;
    logic [DATA_W-1:0] opnd;
    logic [2:0]        mode;
    logic [1:0]        op;
    logic [ACC_W-1:0]  acc;
    logic [HALF_W-1:0] half;
  } mth_vec_s;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rdv;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  int                fails = 0;
  int                cmp_count = 0;

  // Lane zero cases: rounding select, operands, mode, op, accumulator, low half
  mth_vec_s vecs [12] = '{
    '{1'b0, 32'h80008000, MODE_DEFAULT, OP_LOAD, 40'h007FFFFFFF, 16'h7FFF},
    '{1'b0, 32'h0003FFFF, MODE_SINT, OP_LOAD, 40'hFFFFFFFFFD, 16'hFFFD},
    '{1'b0, 32'h7FFF7FFF, MODE_SINT, OP_ADD, 40'h003FFEFFFE, 16'h7FFF},
    '{1'b0, 32'hFFFFFFFF, MODE_UINT, OP_LOAD, 40'h00FFFE0001, 16'hFFFF},
    '{1'b0, 32'h00020001, MODE_UINT, OP_LOAD, 40'h0000000002, 16'h0002},
    '{1'b0, 32'hFFFFFFFF, MODE_UINT, OP_SUB, 40'h0000000000, 16'h0000},
    '{1'b0, 32'h40000001, MODE_DEFAULT, OP_LOAD, 40'h0000008000, 16'h0000},
    '{1'b0, 32'h40000003, MODE_DEFAULT, OP_LOAD, 40'h0000018000, 16'h0002},
    '{1'b0, 32'h4000FFFF, MODE_CHOP, OP_LOAD, 40'hFFFFFF8000, 16'hFFFF},
    '{1'b1, 32'h40000001, MODE_DEFAULT, OP_LOAD, 40'h0000008000, 16'h0001},
    '{1'b0, 32'hFFFFFFFF, MODE_UFRAC, OP_LOAD, 40'h00FFFE0001, 16'hFFFE},
    '{1'b0, 32'h80008000, MODE_DEFAULT, OP_SUB, 40'h007FFE0002, 16'h7FFE}
  };

  mth_mac_half DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  mth_host host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // Clock at 125 MHz
  always #4 aclk = ~aclk;

  // Compare, count and report
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Register read with expected word and OKAY response
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    host.rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic acc_chk(input logic [ADDR_W-1:0] lo, input logic [ACC_W-1:0] e);
    rd_chk(lo, e[31:0]);
    rd_chk(lo + 8'h04, {24'h0, e[39:32]});
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(FLAGS_OFS, REG_RST);
    acc_chk(ACC1_LO_OFS, ACC_RST);
    host.rd(8'h40, rdv, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    check(rdv, 32'h0);
    host.wr(8'h40, 32'hFFFFFFFF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    host.wr(ACC1_LO_OFS, 32'h12345678, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    acc_chk(ACC1_LO_OFS, ACC_RST);
    foreach (vecs[i]) begin
      host.stall = i % 3;
      host.wr(FLAGS_OFS, {31'h0, vecs[i].rnd}, rsp);
      host.wr(OPND0_OFS, vecs[i].opnd, rsp);
      host.wr(CMD_OFS, host.cmd(vecs[i].op, OP_LOAD, 2'b01, vecs[i].mode, 1'b0), rsp);
      acc_chk(ACC0_LO_OFS, vecs[i].acc);
      host.rd(DEST_OFS, rdv, rsp);
      check(rdv, {16'h0, vecs[i].half});
    end
    host.wr(OPND1_OFS, 32'h80008000, rsp);
    host.wr(CMD_OFS, host.cmd(OP_LOAD, OP_LOAD, 2'b10, MODE_UFRAC, 1'b0), rsp);
    acc_chk(ACC1_LO_OFS, 40'h0040000000);
    acc_chk(ACC0_LO_OFS, 40'h007FFE0002);
    rd_chk(DEST_OFS, 32'h40007FFE);
    host.wr(OPND0_OFS, 32'h80004000, rsp);
    host.wr(OPND1_OFS, 32'h80004000, rsp);
    host.wr(CMD_OFS, host.cmd(OP_LOAD, OP_LOAD, 2'b11, MODE_DEFAULT, 1'b1), rsp);
    acc_chk(ACC0_LO_OFS, 40'hFFC0000000);
    acc_chk(ACC1_LO_OFS, 40'h0020000000);
    rd_chk(DEST_OFS, 32'h2000C000);
    host.stall = 0;
    host.wr(OPND0_OFS, 32'h80008000, rsp);
    host.wr(OPND1_OFS, 32'h80008000, rsp);
    repeat (260) host.wr(CMD_OFS, host.cmd(OP_ADD, OP_SUB, 2'b11, MODE_DEFAULT, 1'b0), rsp);
    acc_chk(ACC0_LO_OFS, ACC_SMAX);
    acc_chk(ACC1_LO_OFS, ACC_SMIN);
    rd_chk(DEST_OFS, 32'h80007FFF);
    host.wr(DEST_OFS, 32'h12345678, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd_chk(DEST_OFS, 32'h12345678);
    wrap_up();
  end
endmodule
